// file: tpcl_top.sv
// command latch pair of the loop test accessory: backplane channel 0 to relay controls
`timescale 1ns/1ns
// Summary of operation
// RQ1: Two independent command latches each terminate the backplane bus and drive parallel controls.
// RQ2: The central controller sends command bits serially on the downstream data line.
// RQ3: Data is taken only in channel 0 while that latch's enable is active, and ignored otherwise.
// RQ4: Each transaction carries exactly one byte; a transaction cut short before its eighth bit stores nothing.
// RQ5: At the end of a transaction the byte is latched onto eight outputs and held until replaced.
// RQ6: During the same transaction the previously held byte is shifted out upstream.
// RQ7: The controller compares the echoed byte with what it sent before to confirm the write.
// RQ8: Upstream data is inverted and driven through an open-collector stage.
// RQ9: All latch outputs are zero at power-up or insertion, before any transaction.
// RQ10: With alarm reporting enabled the second latch's failure input reads 0 healthy and 1 failed.
// RQ11: The converter failure status is returned to the controller on every query of that latch.
// RQ12: Alarm reporting stays disabled by its switches until controller software can use it.
// RQ13: The two latches together give sixteen relay controls for the four test ports.
// RQ14: Each port takes one nibble; port 1 is the upper nibble of the first latch, P0 is the nibble MSB.
// RQ15: The all-zero nibble is the bypass state, both at power-up and at rest.
// RQ16: The controller never writes an odd nibble value to any port.
// RQ17: Bits travel most significant first, both downstream and in the upstream echo.
module tpcl_top
  import tpcl_pkg::*;
(
  input  wire logic                                  i_clk,
  input  wire logic                                  i_rstn,
  input  wire logic                                  i_bus_clk,
  input  wire logic                                  i_frame,
  input  wire logic                                  i_rdata,
  input  wire logic [tpcl_pkg::LATCH_COUNT-1:0]      i_latch_en,
  input  wire logic                                  i_conv_healthy,
  input  wire logic                                  i_alarm_route_switch,
  input  wire logic                                  i_alarm_inhibit_switch,
  output logic                                       o_tdata_out,
  output logic                                       o_tdata_oe_n,
  output logic [tpcl_pkg::DATA_BITS-1:0]             o_first_latch,
  output logic [tpcl_pkg::DATA_BITS-1:0]             o_second_latch,
  output logic [tpcl_pkg::LATCH_COUNT*tpcl_pkg::DATA_BITS-1:0] o_relay,
  output logic [tpcl_pkg::NIBBLE_BITS-1:0]           o_port1_code,
  output logic [tpcl_pkg::NIBBLE_BITS-1:0]           o_port2_code,
  output logic [tpcl_pkg::NIBBLE_BITS-1:0]           o_port3_code,
  output logic [tpcl_pkg::NIBBLE_BITS-1:0]           o_port4_code,
  output logic                                       o_transfer_done
);
  import tpcl_pkg::*;

  localparam int unsigned SYNC_W = LATCH_COUNT + 6;
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(SLOT_BITS - 1);
  localparam logic [CNT_W-1:0] LAST_DATA = CNT_W'(DATA_BITS - 1);

  // ==========================================================================
  // pin synchronisers
  logic [SYNC_W-1:0] pins_sync;
  logic              bclk_s;
  logic              frame_s;
  logic              rdata_s;
  logic              healthy_s;
  logic              route_s;
  logic              inhibit_s;
  logic [LATCH_COUNT-1:0] en_s;

  tpcl_sync #(
    .WIDTH (SYNC_W)
  ) u_sync (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_async ({i_latch_en, i_alarm_inhibit_switch, i_alarm_route_switch,
               i_conv_healthy, i_rdata, i_frame, i_bus_clk}),
    .o_sync  (pins_sync)
  );

  assign bclk_s    = pins_sync[0];
  assign frame_s   = pins_sync[1];
  assign rdata_s   = pins_sync[2];
  assign healthy_s = pins_sync[3];
  assign route_s   = pins_sync[4];
  assign inhibit_s = pins_sync[5];
  assign en_s      = pins_sync[SYNC_W-1:6];

  // ==========================================================================
  // edge detection of the bus clock and frame
  logic bclk_prev_q;
  logic bclk_prev_d;
  logic frame_prev_q;
  logic frame_prev_d;
  logic bit_tick;
  logic frame_tick;

  always_comb begin
    bclk_prev_d  = bclk_s;
    frame_prev_d = frame_s;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bclk_prev_q  <= 1'b0;
      frame_prev_q <= 1'b0;
    end else begin
      bclk_prev_q  <= bclk_prev_d;
      frame_prev_q <= frame_prev_d;
    end
  end

  assign bit_tick   = bclk_s & ~bclk_prev_q;
  assign frame_tick = frame_s & ~frame_prev_q;

  // ==========================================================================
  // channel 0 bit counter, shared by both latches
  logic [CNT_W-1:0] bit_cnt_q;
  logic [CNT_W-1:0] bit_cnt_d;
  logic             in_ch0_q;
  logic             in_ch0_d;

  always_comb begin
    bit_cnt_d = bit_cnt_q;
    in_ch0_d  = in_ch0_q;
    // RQ3: channel 0 window
    if (frame_tick) begin
      bit_cnt_d = CNT_RESET;
      in_ch0_d  = 1'b1;
    end else if (bit_tick && in_ch0_q) begin
      if (bit_cnt_q == LAST_BIT) begin
        in_ch0_d = 1'b0;
      end else begin
        bit_cnt_d = bit_cnt_q + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_cnt_q <= CNT_RESET;
      in_ch0_q  <= 1'b0;
    end else begin
      bit_cnt_q <= bit_cnt_d;
      in_ch0_q  <= in_ch0_d;
    end
  end

  // ==========================================================================
  // converter failure status
  logic conv_fail;
  // RQ10: failure reads 1 only when routed and not inhibited
  assign conv_fail = route_s & ~inhibit_s & ~healthy_s;

  // ==========================================================================
  // the two command latches
  logic [DATA_BITS-1:0]   latch_q [LATCH_COUNT];
  logic [LATCH_COUNT-1:0] drive_low_d;
  logic [LATCH_COUNT-1:0] done_d;

  // RQ1: one independent latch per generate pass
  for (genvar g = 0; g < LATCH_COUNT; g++) begin : g_latch
    tpcl_state_type       state_q;
    tpcl_state_type       state_d;
    logic [DATA_BITS-1:0] shin_q;
    logic [DATA_BITS-1:0] shin_d;
    logic [SLOT_BITS-1:0] echo_q;
    logic [SLOT_BITS-1:0] echo_d;
    logic [DATA_BITS-1:0] latch_d;
    logic                 stat_bit;

    assign stat_bit = (g == STATUS_LATCH) ? conv_fail : 1'b0;

    always_comb begin
      state_d     = state_q;
      shin_d      = shin_q;
      echo_d      = echo_q;
      latch_d     = latch_q[g];
      done_d[g]   = 1'b0;
      drive_low_d[g] = 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (frame_tick && en_s[g]) begin
            // RQ6: echo loads the byte about to be replaced
            // RQ11: status rides along on every query
            echo_d  = '0;
            echo_d[SLOT_BITS-1 -: DATA_BITS] = latch_q[g];
            echo_d[SLOT_BITS-1-STATUS_POS]   = stat_bit;
            state_d = ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!en_s[g] || frame_tick) begin
            // RQ4: a transfer cut before its eighth bit stores nothing
            state_d = ST_IDLE;
          end else if (bit_tick && in_ch0_q) begin
            // RQ17: msb first both ways
            shin_d = {shin_q[DATA_BITS-2:0], rdata_s};
            echo_d = {echo_q[SLOT_BITS-2:0], 1'b0};
            if (bit_cnt_q == LAST_DATA) begin
              // RQ5: whole byte latched and held
              latch_d   = {shin_q[DATA_BITS-2:0], rdata_s};
              done_d[g] = 1'b1;
            end
            if (bit_cnt_q == LAST_BIT) begin
              state_d = ST_IDLE;
            end
          end
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
      // RQ8: a one bit pulls the line low, inverting the data
      if (state_d == ST_SHIFT) begin
        drive_low_d[g] = echo_d[SLOT_BITS-1];
      end
    end

    // RQ9: outputs clear at power-up
    always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
        state_q    <= ST_IDLE;
        shin_q     <= LATCH_RESET;
        echo_q     <= '0;
        latch_q[g] <= LATCH_RESET;
      end else begin
        state_q    <= state_d;
        shin_q     <= shin_d;
        echo_q     <= echo_d;
        latch_q[g] <= latch_d;
      end
    end
  end

  // ==========================================================================
  // open-collector upstream stage and completion flag
  logic oe_n_q;
  logic oe_n_d;
  logic done_q;
  logic done_q_d;

  always_comb begin
    // RQ8: wired open collectors of both latches
    oe_n_d   = ~(|drive_low_d);
    done_q_d = |done_d;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      oe_n_q <= 1'b1;
      done_q <= 1'b0;
    end else begin
      oe_n_q <= oe_n_d;
      done_q <= done_q_d;
    end
  end

  // the collector can only sink, so the driven level is always low
  assign o_tdata_out     = 1'b0;
  assign o_tdata_oe_n    = oe_n_q;
  assign o_transfer_done = done_q;

  // ==========================================================================
  // relay controls and per-port nibbles
  // RQ13: sixteen relay controls
  assign o_first_latch  = latch_q[0];
  assign o_second_latch = latch_q[1];
  assign o_relay        = {latch_q[0], latch_q[1]};
  // RQ14: upper nibble first, P0 as msb
  // RQ15: zero nibble is bypass, the reset value
  assign o_port1_code   = latch_q[0][7:4];
  assign o_port2_code   = latch_q[0][3:0];
  assign o_port3_code   = latch_q[1][7:4];
  assign o_port4_code   = latch_q[1][3:0];
endmodule // tpcl_top

// file: tpcl_pkg.sv
// constants and types shared by the test port command latch design
package tpcl_pkg;
  // ==========================================================================
  // backplane timeslot framing
  localparam int unsigned SLOT_BITS    = 10;
  localparam int unsigned DATA_BITS    = 8;
  localparam int unsigned STATUS_POS   = 8;
  localparam int unsigned LATCH_COUNT  = 2;
  localparam int unsigned PORT_COUNT   = 4;
  localparam int unsigned NIBBLE_BITS  = 4;
  localparam int unsigned SYNC_STAGES  = 2;
  localparam int unsigned CNT_W        = 4;
  localparam int unsigned STATUS_LATCH = 1;
  // ==========================================================================
  // reset values
  localparam logic [7:0] LATCH_RESET   = 8'h00;
  localparam logic [3:0] CNT_RESET     = 4'h0;
  // ==========================================================================
  // per-latch transaction state
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_SHIFT
  } tpcl_state_type;
endpackage : tpcl_pkg

// file: tpcl_sync.sv
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module tpcl_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  // ==========================================================================
  // first stage is read only by the second
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule // tpcl_sync

// file: tpcl_ctrl_model.sv
// controller side model: frames a channel-0 slot and reads back the echo
`timescale 1ns/1ns
module tpcl_ctrl_model (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_bus_clk,
  output logic      o_frame,
  output logic      o_rdata
);
  initial begin
    o_bus_clk = 1'b0;
    o_frame   = 1'b0;
    o_rdata   = 1'b0;
  end
  // ==========
  // slot transfer
  // one byte, msb first
  task automatic xfer(input logic [7:0] d, output logic [9:0] e);
    int k;
    repeat (2) @(negedge i_clk);
    o_frame = 1'b1;
    for (k = 0; k < 10; k++) begin
      repeat (3) @(negedge i_clk);
      o_rdata = (k < 8) ? d[7-k] : 1'b0;
      repeat (4) @(negedge i_clk);
      e[9-k] = ~i_line;
      o_bus_clk = 1'b1;
      repeat (4) @(negedge i_clk);
      o_bus_clk = 1'b0;
    end
    repeat (2) @(negedge i_clk);
    // stale data must not look valid
    o_rdata = ~o_rdata;
    o_frame = 1'b0;
  endtask
endmodule // tpcl_ctrl_model

// file: tpcl_top_sva.sv
// port assertions for the command latch pair
`timescale 1ns/1ns
module tpcl_top_sva
  import tpcl_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic [1:0]  i_latch_en,
  input wire logic        o_tdata_out,
  input wire logic        o_tdata_oe_n,
  input wire logic [7:0]  o_first_latch,
  input wire logic [7:0]  o_second_latch,
  input wire logic [15:0] o_relay,
  input wire logic [3:0]  o_port1_code,
  input wire logic [3:0]  o_port2_code,
  input wire logic [3:0]  o_port3_code,
  input wire logic [3:0]  o_port4_code,
  input wire logic        o_transfer_done
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // ==========
  // properties
  property p_rst_clear;
    $rose(i_rstn) |-> o_relay == 16'h0000 && o_tdata_oe_n;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("outputs not clear after reset");
  property p_relay_map;
    o_relay == {o_first_latch, o_second_latch};
  endproperty
  a_relay_map: assert property (p_relay_map) else $error("relay bus differs from latches");
  property p_port_map;
    {o_port1_code, o_port2_code, o_port3_code, o_port4_code} == o_relay;
  endproperty
  a_port_map: assert property (p_port_map) else $error("port nibble map wrong");
  property p_update_done;
    $changed(o_relay) |-> o_transfer_done;
  endproperty
  a_update_done: assert property (p_update_done) else $error("no done after latch update");
  property p_done_pulse;
    o_transfer_done |=> !o_transfer_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
  property p_oc_drive;
    o_tdata_out == 1'b0;
  endproperty
  a_oc_drive: assert property (p_oc_drive) else $error("echo drive not low");
  property p_idle_release;
    (i_latch_en == 2'b00) [*5] |-> o_tdata_oe_n;
  endproperty
  a_idle_release: assert property (p_idle_release) else $error("echo driven with no enable");
  property p_no_en_hold;
    !i_latch_en[0] [*6] |=> $stable(o_first_latch);
  endproperty
  a_no_en_hold: assert property (p_no_en_hold) else $error("first latch moved while disabled");
  c_done: cover property (o_transfer_done);
  c_echo: cover property ($fell(o_tdata_oe_n));
  c_second: cover property ($changed(o_second_latch));
endmodule // tpcl_top_sva
bind tpcl_top tpcl_top_sva u_sva (.i_clk(i_clk), .i_rstn(i_rstn), .i_latch_en(i_latch_en),
  .o_tdata_out(o_tdata_out), .o_tdata_oe_n(o_tdata_oe_n), .o_first_latch(o_first_latch),
  .o_second_latch(o_second_latch), .o_relay(o_relay), .o_port1_code(o_port1_code),
  .o_port2_code(o_port2_code), .o_port3_code(o_port3_code), .o_port4_code(o_port4_code),
  .o_transfer_done(o_transfer_done));

// file: tpcl_top_tb.sv
// self-checking bench for the command latch pair
`timescale 1ns/1ns
module tpcl_top_tb;
  import tpcl_pkg::*;
  logic        i_clk, i_rstn, bus_clk, frame, rdata, line, healthy, route, inhibit, done, oe_n, drv;
  logic [1:0]  en;
  logic [7:0]  first, second;
  logic [15:0] relay;
  logic [3:0]  p1, p2, p3, p4;
  logic [9:0]  e;
  int          miscompares, compares, ndone;
  // pull-up on the shared echo line
  assign line = oe_n ? 1'b1 : drv;
  tpcl_top dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_bus_clk(bus_clk), .i_frame(frame), .i_rdata(rdata),
    .i_latch_en(en), .i_conv_healthy(healthy), .i_alarm_route_switch(route), .i_alarm_inhibit_switch(inhibit),
    .o_tdata_out(drv), .o_tdata_oe_n(oe_n), .o_first_latch(first), .o_second_latch(second), .o_relay(relay),
    .o_port1_code(p1), .o_port2_code(p2), .o_port3_code(p3), .o_port4_code(p4), .o_transfer_done(done));
  tpcl_ctrl_model ctrl (.i_clk(i_clk), .i_line(line), .o_bus_clk(bus_clk), .o_frame(frame), .o_rdata(rdata));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  always @(posedge i_clk) if (done === 1'b1) ndone++;
  // ==========
  // helpers
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [7:0] d, input logic [9:0] x);
    @(negedge i_clk) en = sel;
    ctrl.xfer(d, e);
    chk("echo", {6'h00, x}, {6'h00, e});
  endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset;
    chk("relay", 16'h0000, relay);
    chk("oe_n", 16'h0001, {15'h0000, oe_n});
    chk("ports", 16'h0000, {p1, p2, p3, p4});
  endtask
  task automatic t_echo;
    wr(2'b01, 8'hA4, {8'h00, 2'b00});
    wr(2'b01, 8'h2C, {8'hA4, 2'b00});
    chk("relay", 16'h2C00, relay);
  endtask
  task automatic t_status;
    route = 1'b1;
    healthy = 1'b0;
    wr(2'b10, 8'h4A, {8'h00, 2'b10});
    healthy = 1'b1;
    wr(2'b10, 8'hC6, {8'h4A, 2'b00});
    chk("ports", 16'h2CC6, {p1, p2, p3, p4});
    inhibit = 1'b1;
    healthy = 1'b0;
    wr(2'b10, 8'h00, {8'hC6, 2'b00});
    chk("first", 16'h002C, {8'h00, first});
  endtask
  task automatic t_ignore;
    wr(2'b00, 8'hEE, 10'h000);
    chk("relay", 16'h2C00, relay);
  endtask
  task automatic t_abort;
    @(negedge i_clk) en = 2'b01;
    fork
      ctrl.xfer(8'h80, e);
      begin
        repeat (40) @(negedge i_clk);
        en = 2'b00;
      end
    join
    chk("first", 16'h002C, {8'h00, first});
    chk("oe_n", 16'h0001, {15'h0000, oe_n});
    wr(2'b01, 8'h28, {8'h2C, 2'b00});
    chk("done", 16'h0006, ndone[15:0]);
  endtask
  task automatic t_reinsert;
    @(negedge i_clk) i_rstn = 1'b0;
    repeat (2) @(negedge i_clk);
    chk("relay", 16'h0000, relay);
    chk("ports", 16'h0000, {p1, p2, p3, p4});
    i_rstn = 1'b1;
    repeat (4) @(negedge i_clk);
    wr(2'b01, 8'h42, {8'h00, 2'b00});
  endtask
  // ==========
  // main sequence
  initial begin
    i_rstn = 1'b0;
    en = 2'b00;
    healthy = 1'b1;
    route = 1'b0;
    inhibit = 1'b0;
    repeat (10) @(negedge i_clk);
    i_rstn = 1'b1;
    repeat (4) @(negedge i_clk);
    t_reset();
    t_echo();
    t_status();
    t_ignore();
    t_abort();
    t_reinsert();
    end_sim();
  end
  // about 9 slots of 115 cycles each; generous margin
  initial begin
    repeat (5000) @(posedge i_clk);
    miscompares++;
    end_sim();
  end
endmodule // tpcl_top_tb
